/* File: core/rx_control_defines.vh */
// register offsets, field positions, reset values and codes of the receiver control bank
`ifndef RX_CONTROL_DEFINES_VH
`define RX_CONTROL_DEFINES_VH

`define ADDR_EVENT_ENABLE 7'h3F
`define ADDR_OUTPUT_PIN_SELECT 7'h40
`define ADDR_IRQ_LINE_SELECT 7'h41
`define ADDR_EVENT_CLEAR 7'h42
`define ADDR_EVENT_FLAGS 7'h43
`define ADDR_FIFO_FLAGS 7'h44
`define ADDR_SIGNAL_STRENGTH 7'h45
`define ADDR_FUNCTION_ENABLE 7'h46
`define ADDR_OPERATING_STATE 7'h47
`define ADDR_SOFT_RESET 7'h4F

`define RST_EVENT_ENABLE 8'h00
`define RST_OUTPUT_PIN_SELECT 8'h00
`define RST_IRQ_LINE_SELECT 8'h00
`define RST_FUNCTION_ENABLE 8'h04
`define RST_STATE_COMMAND 5'h00

`define BIT_SLEEP_TIMEOUT 7
`define BIT_RECEIVE_TIMEOUT 6
`define BIT_STRENGTH_VALID 5
`define BIT_PREAMBLE_PASS 4
`define BIT_SYNCWORD_PASS 3
`define BIT_NODE_PASS 2
`define BIT_CHECKSUM_PASS 1
`define BIT_PACKET_DONE 0

`define FIELD_OUT_FOUR 7:6
`define FIELD_OUT_THREE 5:4
`define FIELD_OUT_TWO 3:2
`define FIELD_OUT_ONE 1:0
`define FIELD_IRQ_TWO 7:4
`define FIELD_IRQ_ONE 3:0
`define FIELD_STATE_COMMAND 4:0
`define BIT_QUEUE_FLUSH 2
`define BIT_SLEEP_TIMER_STOP 6
`define BIT_TEST_MODE 5
`define BIT_FAST_SPI 2

`define STATE_POWER_UP 3'h0
`define STATE_SLEEP 3'h1
`define STATE_STANDBY 3'h2
`define STATE_TUNE 3'h3
`define STATE_RECEIVE 3'h4
`define STATE_MEMORY 3'h5

`define CMD_GO_MEMORY 5'h01
`define CMD_GO_STANDBY 5'h02
`define CMD_GO_TUNE 5'h04
`define CMD_GO_RECEIVE 5'h08
`define CMD_GO_SLEEP 5'h10

`define MODE_DIRECT 2'h0
`define MODE_BUFFER 2'h1
`define MODE_PACKET 2'h2

`define SOFT_RESET_KEY 8'hFF
`define SPI_READ_FLAG 1'b1

`endif

/* File: core/irq_source_mux.v */
// per-mode event selector for one interrupt line
`timescale 1ns/10ps
`include "rx_control_defines.vh"

module irq_source_mux (
    input wire [3:0] source_select,
    input wire [1:0] data_mode,
    input wire [7:0] event_flags,
    input wire queue_full,
    input wire queue_not_empty,
    input wire queue_threshold,
    input wire queue_overflow,
    input wire byte_written_strobe,
    input wire strength_indicator,
    output reg irq_level
);

    always @* begin
        irq_level = 1'b0;
        case (source_select)
            4'h1: irq_level = event_flags[`BIT_STRENGTH_VALID];
            4'h2: irq_level = event_flags[`BIT_PREAMBLE_PASS];
            4'h3: irq_level = event_flags[`BIT_SYNCWORD_PASS];
            default: begin
                if (data_mode == `MODE_PACKET) begin
                    case (source_select)
                        4'h4: irq_level = event_flags[`BIT_NODE_PASS];
                        4'h5: irq_level = event_flags[`BIT_CHECKSUM_PASS];
                        4'h6: irq_level = event_flags[`BIT_PACKET_DONE];
                        4'h7: irq_level = event_flags[`BIT_SLEEP_TIMEOUT];
                        4'h8: irq_level = event_flags[`BIT_RECEIVE_TIMEOUT];
                        4'h9: irq_level = queue_not_empty;
                        4'hA: irq_level = queue_threshold;
                        4'hB: irq_level = queue_full;
                        4'hC: irq_level = byte_written_strobe;
                        4'hD: irq_level = queue_overflow;
                        4'hE: irq_level = strength_indicator;
                        default: irq_level = 1'b0;
                    endcase
                end else if (data_mode == `MODE_BUFFER) begin
                    case (source_select)
                        4'h4: irq_level = event_flags[`BIT_SLEEP_TIMEOUT];
                        4'h5: irq_level = event_flags[`BIT_RECEIVE_TIMEOUT];
                        4'h6: irq_level = queue_not_empty;
                        4'h7: irq_level = queue_threshold;
                        4'h8: irq_level = queue_full;
                        4'h9: irq_level = byte_written_strobe;
                        4'hA: irq_level = queue_overflow;
                        4'hB: irq_level = strength_indicator;
                        default: irq_level = 1'b0;
                    endcase
                end else begin
                    // unused mode code 11 behaves as direct mode
                    case (source_select)
                        4'h4: irq_level = event_flags[`BIT_SLEEP_TIMEOUT];
                        4'h5: irq_level = event_flags[`BIT_RECEIVE_TIMEOUT];
                        4'h6: irq_level = strength_indicator;
                        default: irq_level = 1'b0;
                    endcase
                end
            end
        endcase
    end

endmodule

/* File: core/spi_frame_slave.v */
// four-wire spi slave: one address byte then one data byte per frame
`timescale 1ns/10ps
`include "rx_control_defines.vh"

module spi_frame_slave (
    input wire sys_clk,
    input wire rst_n,
    input wire spi_clk,
    input wire spi_csb,
    input wire spi_mosi,
    input wire [7:0] read_data,
    output reg [6:0] access_addr,
    output reg write_strobe,
    output reg [7:0] write_data,
    output reg spi_miso,
    output reg spi_miso_oe
);

    reg [1:0] clk_sync_reg;
    reg [1:0] csb_sync_reg;
    reg [1:0] mosi_sync_reg;
    reg clk_prev_reg;
    reg [3:0] bit_count_reg;
    reg [7:0] shift_in_reg;
    reg [7:0] shift_out_reg;
    reg [1:0] phase_reg;
    reg is_read_reg;
    reg load_pending_reg;
    wire clk_rise;
    wire clk_fall;
    wire [7:0] byte_in;

    assign clk_rise = clk_sync_reg[1] & ~clk_prev_reg;
    assign clk_fall = ~clk_sync_reg[1] & clk_prev_reg;
    assign byte_in = {shift_in_reg[6:0], mosi_sync_reg[1]};

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            clk_sync_reg <= 2'h0;
            csb_sync_reg <= 2'h3;
            mosi_sync_reg <= 2'h0;
            clk_prev_reg <= 1'b0;
            bit_count_reg <= 4'h0;
            shift_in_reg <= 8'h00;
            shift_out_reg <= 8'h00;
            phase_reg <= 2'h0;
            is_read_reg <= 1'b0;
            load_pending_reg <= 1'b0;
            access_addr <= 7'h00;
            write_strobe <= 1'b0;
            write_data <= 8'h00;
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else begin
            clk_sync_reg <= {clk_sync_reg[0], spi_clk};
            csb_sync_reg <= {csb_sync_reg[0], spi_csb};
            mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi};
            clk_prev_reg <= clk_sync_reg[1];
            write_strobe <= 1'b0;
            if (csb_sync_reg[1]) begin
                bit_count_reg <= 4'h0;
                phase_reg <= 2'h0;
                load_pending_reg <= 1'b0;
                spi_miso_oe <= 1'b0;
            end else begin
                if (clk_rise && phase_reg != 2'h2) begin
                    shift_in_reg <= byte_in;
                    bit_count_reg <= bit_count_reg + 4'h1;
                    if (bit_count_reg == 4'h7) begin
                        bit_count_reg <= 4'h0;
                        phase_reg <= phase_reg + 2'h1;
                        if (phase_reg == 2'h0) begin
                            access_addr <= byte_in[6:0];
                            is_read_reg <= (byte_in[7] == `SPI_READ_FLAG);
                            load_pending_reg <= (byte_in[7] == `SPI_READ_FLAG);
                        end else if (!is_read_reg) begin
                            write_data <= byte_in;
                            write_strobe <= 1'b1;
                        end
                    end
                end
                // read data is fetched one cycle after the address settles
                if (load_pending_reg) begin
                    load_pending_reg <= 1'b0;
                    shift_out_reg <= read_data;
                    spi_miso <= read_data[7];
                    spi_miso_oe <= 1'b1;
                end else if (clk_fall && phase_reg == 2'h1 && bit_count_reg != 4'h0 && is_read_reg) begin
                    shift_out_reg <= {shift_out_reg[6:0], 1'b0};
                    spi_miso <= shift_out_reg[6];
                end
            end
        end
    end

endmodule

/* File: core/rx_interrupt_and_output_control.v */
// control register bank of the receiver: events, interrupt lines, output pins, state and soft reset
//
// What this block does
// - event enables at 0x3F, reset disabled
// - output four select in bits 7:6
// - output three select in bits 5:4
// - output two select in bits 3:2
// - output one select in bits 1:0
// - direct mode line two source codes
// - buffer mode line two source codes
// - line one uses bits 3:0, same map
// - byte strobe pulses, no latched flag
// - write one at 0x42 clears event
// - clears act only standby/tune/receive/memory
// - sleep timeout flag, timer running and enabled
// - receive timeout flag, timer running and enabled
// - strength valid flag under frequency shift demodulation
// - 0x44 shows queue flags, bit 2 flushes
// - 0x45 reads current signal strength
// - 0x47 state control, 0x4F soft reset
// - pass and packet flags latch when enabled; node, checksum and packet done only in packet mode
// - queue flags follow queue condition directly
// - one-hot state commands, three-bit state readback
// - 0xFF soft reset, back to power-up, then sleep once power_up_done is seen
`timescale 1ns/10ps
`include "rx_control_defines.vh"

module rx_interrupt_and_output_control (
    input wire sys_clk,
    input wire rst_n,
    input wire spi_clk,
    input wire spi_csb,
    input wire spi_mosi,
    output wire spi_miso,
    output wire spi_miso_oe,
    input wire [1:0] data_mode,
    input wire power_up_done,
    input wire sleep_timer_running,
    input wire sleep_timeout_event,
    input wire receive_timer_running,
    input wire receive_timeout_event,
    input wire fsk_demod_active,
    input wire strength_above_trigger,
    input wire preamble_pass_event,
    input wire syncword_pass_event,
    input wire node_pass_event,
    input wire checksum_pass_event,
    input wire packet_done_event,
    input wire queue_full,
    input wire queue_not_empty,
    input wire queue_threshold,
    input wire queue_overflow,
    input wire byte_written_strobe,
    input wire strength_indicator,
    input wire [7:0] strength_value,
    input wire demod_data,
    input wire recovered_sync_clock,
    input wire system_clock_out,
    input wire reset_out_low,
    output wire general_output_one,
    output wire general_output_two,
    output wire general_output_three,
    output wire general_output_four,
    output wire queue_flush,
    output wire soft_reset_pulse,
    output wire [2:0] operating_state,
    output wire sleep_timer_stop,
    output wire test_mode_enable,
    output wire fast_spi_enable
);

    reg [7:0] event_enable_reg;
    reg [7:0] output_pin_select_reg;
    reg [7:0] irq_line_select_reg;
    reg [7:0] event_flags_reg;
    reg [7:0] event_flags_next;
    reg [7:0] function_enable_reg;
    reg [4:0] state_command_reg;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg soft_reset_reg;
    reg queue_flush_reg;
    reg general_output_one_reg;
    reg general_output_two_reg;
    reg general_output_three_reg;
    reg general_output_four_reg;
    reg general_output_one_next;
    reg general_output_two_next;
    reg general_output_three_next;
    reg general_output_four_next;
    reg [7:0] read_data;
    reg [7:0] event_set;
    reg [7:0] event_clear;

    wire [6:0] access_addr;
    wire write_strobe;
    wire [7:0] write_data;
    wire core_reset;
    wire clear_allowed;
    wire packet_mode;
    wire irq_line_one;
    wire irq_line_two;
    wire write_clear;
    wire write_fifo;
    wire write_state;
    wire write_soft_reset;

    // soft reset acts on the bank like a power-on reset but leaves the spi slave alone,
    // so the frame that carried the command finishes cleanly
    assign core_reset = !rst_n || soft_reset_reg;
    assign packet_mode = (data_mode == `MODE_PACKET);

    assign clear_allowed = (state_reg == `STATE_STANDBY) || (state_reg == `STATE_TUNE) ||
                           (state_reg == `STATE_RECEIVE) || (state_reg == `STATE_MEMORY);

    assign write_clear = write_strobe && (access_addr == `ADDR_EVENT_CLEAR);
    assign write_fifo = write_strobe && (access_addr == `ADDR_FIFO_FLAGS);
    assign write_state = write_strobe && (access_addr == `ADDR_OPERATING_STATE);
    assign write_soft_reset = write_strobe && (access_addr == `ADDR_SOFT_RESET);

    spi_frame_slave spi_slave (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .spi_clk(spi_clk),
        .spi_csb(spi_csb),
        .spi_mosi(spi_mosi),
        .read_data(read_data),
        .access_addr(access_addr),
        .write_strobe(write_strobe),
        .write_data(write_data),
        .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe)
    );

    irq_source_mux irq_one_mux (
        .source_select(irq_line_select_reg[`FIELD_IRQ_ONE]),
        .data_mode(data_mode),
        .event_flags(event_flags_reg),
        .queue_full(queue_full),
        .queue_not_empty(queue_not_empty),
        .queue_threshold(queue_threshold),
        .queue_overflow(queue_overflow),
        .byte_written_strobe(byte_written_strobe),
        .strength_indicator(strength_indicator),
        .irq_level(irq_line_one)
    );

    irq_source_mux irq_two_mux (
        .source_select(irq_line_select_reg[`FIELD_IRQ_TWO]),
        .data_mode(data_mode),
        .event_flags(event_flags_reg),
        .queue_full(queue_full),
        .queue_not_empty(queue_not_empty),
        .queue_threshold(queue_threshold),
        .queue_overflow(queue_overflow),
        .byte_written_strobe(byte_written_strobe),
        .strength_indicator(strength_indicator),
        .irq_level(irq_line_two)
    );

    // event sources, each gated by its enable; a cleared enable blocks new sets only
    always @* begin
        event_set = 8'h00;
        event_set[`BIT_SLEEP_TIMEOUT] = sleep_timeout_event && sleep_timer_running &&
                                        event_enable_reg[`BIT_SLEEP_TIMEOUT];
        event_set[`BIT_RECEIVE_TIMEOUT] = receive_timeout_event && receive_timer_running &&
                                          event_enable_reg[`BIT_RECEIVE_TIMEOUT];
        event_set[`BIT_STRENGTH_VALID] = fsk_demod_active && strength_above_trigger &&
                                         event_enable_reg[`BIT_STRENGTH_VALID];
        event_set[`BIT_PREAMBLE_PASS] = preamble_pass_event && event_enable_reg[`BIT_PREAMBLE_PASS];
        event_set[`BIT_SYNCWORD_PASS] = syncword_pass_event && event_enable_reg[`BIT_SYNCWORD_PASS];
        event_set[`BIT_NODE_PASS] = node_pass_event && packet_mode && event_enable_reg[`BIT_NODE_PASS];
        event_set[`BIT_CHECKSUM_PASS] = checksum_pass_event && packet_mode &&
                                        event_enable_reg[`BIT_CHECKSUM_PASS];
        event_set[`BIT_PACKET_DONE] = packet_done_event && packet_mode &&
                                      event_enable_reg[`BIT_PACKET_DONE];
    end

    // a set arriving in the same cycle as its clear wins
    always @* begin
        event_clear = 8'h00;
        if (write_clear && clear_allowed) begin
            event_clear = write_data;
        end
        event_flags_next = event_set | (event_flags_reg & ~event_clear);
    end

    // operating state: power-up waits for the sequence, then sleep; only one-hot commands move it
    always @* begin
        state_next = state_reg;
        if (state_reg == `STATE_POWER_UP) begin
            if (power_up_done) begin
                state_next = `STATE_SLEEP;
            end
        end else if (write_state) begin
            case (write_data[`FIELD_STATE_COMMAND])
                `CMD_GO_MEMORY: state_next = `STATE_MEMORY;
                `CMD_GO_STANDBY: state_next = `STATE_STANDBY;
                `CMD_GO_TUNE: state_next = `STATE_TUNE;
                `CMD_GO_RECEIVE: state_next = `STATE_RECEIVE;
                `CMD_GO_SLEEP: state_next = `STATE_SLEEP;
                default: state_next = state_reg;
            endcase
        end
    end

    // pin routing from the live interrupt levels, registered once on the way out
    always @* begin
        case (output_pin_select_reg[`FIELD_OUT_FOUR])
            2'h0: general_output_four_next = demod_data;
            2'h1: general_output_four_next = irq_line_one;
            2'h2: general_output_four_next = irq_line_two;
            default: general_output_four_next = recovered_sync_clock;
        endcase
        case (output_pin_select_reg[`FIELD_OUT_THREE])
            2'h0: general_output_three_next = system_clock_out;
            2'h1: general_output_three_next = irq_line_one;
            2'h2: general_output_three_next = irq_line_two;
            default: general_output_three_next = demod_data;
        endcase
        case (output_pin_select_reg[`FIELD_OUT_TWO])
            2'h0: general_output_two_next = irq_line_one;
            2'h1: general_output_two_next = irq_line_two;
            2'h2: general_output_two_next = recovered_sync_clock;
            default: general_output_two_next = 1'b0;
        endcase
        case (output_pin_select_reg[`FIELD_OUT_ONE])
            2'h0: general_output_one_next = reset_out_low;
            2'h1: general_output_one_next = irq_line_one;
            2'h2: general_output_one_next = irq_line_two;
            default: general_output_one_next = demod_data;
        endcase
    end

    // register read mux; the clear and soft reset registers are write-only and read zero
    always @* begin
        case (access_addr)
            `ADDR_EVENT_ENABLE: read_data = event_enable_reg;
            `ADDR_OUTPUT_PIN_SELECT: read_data = output_pin_select_reg;
            `ADDR_IRQ_LINE_SELECT: read_data = irq_line_select_reg;
            `ADDR_EVENT_FLAGS: read_data = event_flags_reg;
            `ADDR_FIFO_FLAGS: read_data = {1'b0, queue_full, queue_not_empty,
                                           queue_threshold, queue_overflow, 3'h0};
            `ADDR_SIGNAL_STRENGTH: read_data = strength_value;
            `ADDR_FUNCTION_ENABLE: read_data = function_enable_reg;
            `ADDR_OPERATING_STATE: read_data = {state_reg, state_command_reg};
            default: read_data = 8'h00;
        endcase
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            soft_reset_reg <= 1'b0;
        end else begin
            soft_reset_reg <= write_soft_reset && (write_data == `SOFT_RESET_KEY);
        end
    end

    always @(posedge sys_clk) begin
        if (core_reset) begin
            event_enable_reg <= `RST_EVENT_ENABLE;
            output_pin_select_reg <= `RST_OUTPUT_PIN_SELECT;
            irq_line_select_reg <= `RST_IRQ_LINE_SELECT;
            function_enable_reg <= `RST_FUNCTION_ENABLE;
            state_command_reg <= `RST_STATE_COMMAND;
            event_flags_reg <= 8'h00;
            state_reg <= `STATE_POWER_UP;
            queue_flush_reg <= 1'b0;
        end else begin
            event_flags_reg <= event_flags_next;
            state_reg <= state_next;
            // sleep keeps the queue and packet handler flushed
            queue_flush_reg <= (state_reg == `STATE_SLEEP) ||
                               (write_fifo && write_data[`BIT_QUEUE_FLUSH] && clear_allowed);
            if (write_strobe) begin
                case (access_addr)
                    `ADDR_EVENT_ENABLE: event_enable_reg <= write_data;
                    `ADDR_OUTPUT_PIN_SELECT: output_pin_select_reg <= write_data;
                    `ADDR_IRQ_LINE_SELECT: irq_line_select_reg <= write_data;
                    `ADDR_FUNCTION_ENABLE: function_enable_reg <= write_data;
                    `ADDR_OPERATING_STATE: state_command_reg <= write_data[`FIELD_STATE_COMMAND];
                    default: state_command_reg <= state_command_reg;
                endcase
            end
        end
    end

    // outputs stay low through reset rather than following their sources
    always @(posedge sys_clk) begin
        if (core_reset) begin
            general_output_one_reg <= 1'b0;
            general_output_two_reg <= 1'b0;
            general_output_three_reg <= 1'b0;
            general_output_four_reg <= 1'b0;
        end else begin
            general_output_one_reg <= general_output_one_next;
            general_output_two_reg <= general_output_two_next;
            general_output_three_reg <= general_output_three_next;
            general_output_four_reg <= general_output_four_next;
        end
    end

    assign general_output_one = general_output_one_reg;
    assign general_output_two = general_output_two_reg;
    assign general_output_three = general_output_three_reg;
    assign general_output_four = general_output_four_reg;
    assign queue_flush = queue_flush_reg;
    assign soft_reset_pulse = soft_reset_reg;
    assign operating_state = state_reg;
    assign sleep_timer_stop = function_enable_reg[`BIT_SLEEP_TIMER_STOP];
    assign test_mode_enable = function_enable_reg[`BIT_TEST_MODE];
    assign fast_spi_enable = function_enable_reg[`BIT_FAST_SPI];

endmodule

/* File: tb/rx_control_checker_sva.sv */
// state, reset and pin assertions for the receiver control bank
`timescale 1ns/10ps
module rx_control_checker (
    input wire sys_clk,
    input wire rst_n,
    input wire spi_csb,
    input wire spi_miso_oe,
    input wire power_up_done,
    input wire queue_flush,
    input wire soft_reset_pulse,
    input wire [2:0] operating_state,
    input wire fast_spi_enable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_reset_state_values: assert property ($rose(rst_n) |-> operating_state == 3'h0 && fast_spi_enable)
        else $error("state or function bits wrong after reset");
    a_state_code_legal: assert property (operating_state <= 3'h5)
        else $error("state code out of range");
    a_powerup_holds: assert property (operating_state == 3'h0 && !power_up_done |=> operating_state == 3'h0)
        else $error("left power-up without power_up_done");
    a_powerup_to_sleep: assert property (operating_state == 3'h0 && power_up_done && !soft_reset_pulse
        |=> operating_state == 3'h1)
        else $error("power-up did not go to sleep");
    a_soft_single_pulse: assert property (soft_reset_pulse |=> !soft_reset_pulse)
        else $error("soft reset pulse longer than one cycle");
    a_soft_to_powerup: assert property (soft_reset_pulse |-> ##[1:2] operating_state == 3'h0)
        else $error("soft reset did not restart power-up");
    a_sleep_flushes: assert property (operating_state == 3'h1 [*2] |-> queue_flush)
        else $error("queue not flushed in sleep");
    a_miso_released: assert property (spi_csb [*6] |-> !spi_miso_oe)
        else $error("miso driven outside a frame");
endmodule

/* File: tb/spi_host_model.sv */
// mode 0 spi host: address byte then data byte per frame
`timescale 1ns/10ps
module spi_host_model (
    input wire sys_clk,
    input wire spi_miso,
    input wire spi_miso_oe,
    output reg spi_clk = 1'b0,
    output reg spi_csb = 1'b1,
    output reg spi_mosi = 1'b0
);
    integer i;
    reg [15:0] sh;
    task half;
        repeat (6) @(negedge sys_clk);
    endtask
    // an undriven miso reads as unknown so a missing answer fails the compare
    task xfer(input [7:0] a, input [7:0] d, output [7:0] q);
        begin
            sh = {a, d};
            spi_csb = 1'b0;
            for (i = 0; i < 16; i = i + 1) begin
                spi_mosi = sh[15 - i];
                half;
                spi_clk = 1'b1;
                q = {q[6:0], spi_miso_oe ? spi_miso : 1'bx};
                half;
                spi_clk = 1'b0;
            end
            half;
            spi_csb = 1'b1;
            spi_mosi = ~spi_mosi;
            half;
        end
    endtask
endmodule

/* File: tb/rx_interrupt_and_output_control_tb.sv */
// self-checking bench for the receiver control bank
`timescale 1ns/10ps
`include "rx_control_defines.vh"
module rx_interrupt_and_output_control_tb;
    reg sys_clk = 1'b0;
    reg rst_n = 1'b0;
    reg [1:0] mode = `MODE_DIRECT;
    reg pud = 1'b0;
    reg run = 1'b0;
    reg wb = 1'b0;
    reg [7:0] ev = 8'h00;
    reg [3:0] qf = 4'h0;
    reg [3:0] pin = 4'h9;
    reg [7:0] q;
    wire spi_clk, spi_csb, spi_mosi, spi_miso, spi_miso_oe;
    wire [3:0] gpo;
    integer n_errors = 0;
    integer tests_run = 0;
    initial forever #2 sys_clk = ~sys_clk;
    spi_host_model host_u (.sys_clk(sys_clk), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .spi_clk(spi_clk),
        .spi_csb(spi_csb), .spi_mosi(spi_mosi));
    rx_interrupt_and_output_control dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .spi_clk(spi_clk), .spi_csb(spi_csb),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .data_mode(mode), .power_up_done(pud),
        .sleep_timer_running(run), .sleep_timeout_event(ev[7]), .receive_timer_running(run),
        .receive_timeout_event(ev[6]), .fsk_demod_active(run), .strength_above_trigger(ev[5]),
        .preamble_pass_event(ev[4]), .syncword_pass_event(ev[3]), .node_pass_event(ev[2]),
        .checksum_pass_event(ev[1]), .packet_done_event(ev[0]), .queue_full(qf[3]), .queue_not_empty(qf[2]),
        .queue_threshold(qf[1]), .queue_overflow(qf[0]), .byte_written_strobe(wb), .strength_indicator(run),
        .strength_value(8'h5A), .demod_data(pin[3]), .recovered_sync_clock(pin[2]), .system_clock_out(pin[1]),
        .reset_out_low(pin[0]), .general_output_one(gpo[0]), .general_output_two(gpo[1]),
        .general_output_three(gpo[2]), .general_output_four(gpo[3]), .queue_flush(), .soft_reset_pulse(),
        .operating_state(), .sleep_timer_stop(), .test_mode_enable(), .fast_spi_enable());
    task chk(input [7:0] got, input [7:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("mismatch at %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [6:0] a, input [7:0] d);
        host_u.xfer({1'b0, a}, d, q);
    endtask
    task rd(input [6:0] a, input [7:0] exp);
        begin
            host_u.xfer({`SPI_READ_FLAG, a}, 8'h00, q);
            chk(q, exp);
        end
    endtask
    // pins are registered: look two cycles after the select
    task pins(input [1:0] m, input [7:0] sel, input [3:0] exp);
        begin
            mode = m;
            wr(`ADDR_IRQ_LINE_SELECT, sel);
            repeat (2) @(negedge sys_clk);
            chk({4'h0, gpo}, {4'h0, exp});
        end
    endtask
    task pulse(input [7:0] v);
        begin
            ev = v;
            @(negedge sys_clk);
            ev = 8'h00;
        end
    endtask
    task stop_test;
        begin
            if (n_errors == 0 && tests_run > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    initial begin
        #100000;
        n_errors = n_errors + 1;
        stop_test;
    end
    initial begin
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        rd(`ADDR_OPERATING_STATE, 8'h00);
        pud = 1'b1;
        rd(`ADDR_EVENT_ENABLE, 8'h00);
        rd(`ADDR_IRQ_LINE_SELECT, 8'h00);
        rd(`ADDR_FUNCTION_ENABLE, 8'h04);
        rd(`ADDR_SIGNAL_STRENGTH, 8'h5A);
        rd(`ADDR_OPERATING_STATE, 8'h20);
        rd(7'h50, 8'h00);
        chk({4'h0, gpo}, 8'h09);
        wr(`ADDR_EVENT_ENABLE, 8'hFF);
        pulse(8'hFF);
        rd(`ADDR_EVENT_FLAGS, 8'h18);
        mode = `MODE_PACKET;
        run = 1'b1;
        pulse(8'hFF);
        rd(`ADDR_EVENT_FLAGS, 8'hFF);
        wr(`ADDR_EVENT_CLEAR, 8'hFF);
        rd(`ADDR_EVENT_FLAGS, 8'hFF);
        wr(`ADDR_OPERATING_STATE, 8'h03);
        rd(`ADDR_OPERATING_STATE, 8'h23);
        wr(`ADDR_OPERATING_STATE, {3'h0, `CMD_GO_STANDBY});
        rd(`ADDR_OPERATING_STATE, 8'h42);
        wr(`ADDR_EVENT_CLEAR, 8'h0F);
        rd(`ADDR_EVENT_FLAGS, 8'hF0);
        wr(`ADDR_EVENT_ENABLE, 8'h00);
        pulse(8'h0F);
        rd(`ADDR_EVENT_FLAGS, 8'hF0);
        pin = 4'h4;
        wr(`ADDR_OUTPUT_PIN_SELECT, 8'h9B);
        pins(`MODE_PACKET, 8'h73, 4'hA);
        wr(`ADDR_OUTPUT_PIN_SELECT, 8'h7D);
        pins(`MODE_PACKET, 8'h37, 4'h9);
        pins(`MODE_DIRECT, 8'h04, 4'h9);
        pins(`MODE_DIRECT, 8'h07, 4'h0);
        pins(`MODE_BUFFER, 8'h0B, 4'h9);
        pins(`MODE_BUFFER, 8'h0C, 4'h0);
        wb = 1'b1;
        pins(`MODE_BUFFER, 8'h09, 4'h9);
        qf = 4'hA;
        rd(`ADDR_FIFO_FLAGS, 8'h50);
        qf = 4'h0;
        rd(`ADDR_FIFO_FLAGS, 8'h00);
        wr(`ADDR_SOFT_RESET, 8'h12);
        rd(`ADDR_OPERATING_STATE, 8'h42);
        wr(`ADDR_SOFT_RESET, `SOFT_RESET_KEY);
        repeat (20) @(negedge sys_clk);
        rd(`ADDR_EVENT_ENABLE, 8'h00);
        rd(`ADDR_OPERATING_STATE, 8'h20);
        stop_test;
    end
endmodule
bind rx_interrupt_and_output_control rx_control_checker chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .spi_csb(spi_csb),
    .spi_miso_oe(spi_miso_oe), .power_up_done(power_up_done), .queue_flush(queue_flush),
    .soft_reset_pulse(soft_reset_pulse), .operating_state(operating_state), .fast_spi_enable(fast_spi_enable));
